//--- design/arf_top.sv
// Function
// [RL1] Format 0: result bits 9..2 go to high byte bits 7..0.
// [RL2] Format 0: result bits 1..0 go to low byte bits 7..6.
// [RL3] Format 1: result bits 9..8 go to high byte bits 1..0.
// [RL4] Format 1: result bits 7..0 go to low byte bits 7..0.
// [RL5] Software ignores reserved result bits and writes nothing meaningful there.
// [RL6] A full acquisition interval passes after channel selection before converting.
// [RL7] Result has 1,024 codes, ten bits split over two bytes.
// [RL8] Sample hold capacitor is never discharged after a conversion.
// [RL9] Both result bytes update together, then hold until next result or write.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "arf_params.svh"

module arf_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic CONV_DONE,
  input wire logic [`ARF_RES_W-1:0] CONV_RESULT,
  output logic CONV_START,
  output logic SAMPLE_TRACK,
  output logic DONE_PULSE,
  output arf_pkg::arf_cfg_t CFG
);
  import arf_pkg::*;

  localparam logic [`ARF_ACQ_W-1:0] ACQ_CYCLES = `ARF_ACQ_W'(`ARF_ACQ_CYCLES);

  // Pack a ten-bit result into the two result bytes
  function automatic logic [15:0] pack_result(
    input logic fmt,
    input logic [`ARF_RES_W-1:0] res
  );
    logic [15:0] v;
    if (fmt) begin
      v = {6'h00, res[9:8], res[7:0]}; // [RL3] [RL4]
    end else begin
      v = {res[9:2], res[1:0], 6'h00}; // [RL1] [RL2]
    end
    return v;
  endfunction

  // Write strobe aimed at one register offset
  function automatic logic wr_hit(
    input logic we,
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return we && (addr == ofs);
  endfunction

  logic [4:0] chan_q, chan_d;
  logic on_q, on_d;
  logic go_q, go_d;
  logic fmt_q, fmt_d;
  logic [2:0] cs_q, cs_d;
  logic nref_q, nref_d;
  logic [1:0] pref_q, pref_d;
  logic [7:0] hi_q, hi_d;
  logic [7:0] lo_q, lo_d;
  logic [`ARF_ACQ_W-1:0] acq_q, acq_d;
  arf_state_t state_q, state_d;
  logic start_q, start_d;
  logic done_q, done_d;
  logic [7:0] rdata_q, rdata_d;
  logic wr_chan, wr_fmt, acq_ok, restart_acq;
  logic [4:0] new_chan;
  logic new_on;

  // Write decodes
  assign wr_chan = wr_hit(WR, ADDR, `ARF_OFS_CHAN_GO);
  assign wr_fmt = wr_hit(WR, ADDR, `ARF_OFS_FMT_REF);
  assign new_chan = WDATA[`ARF_CHAN_MSB:`ARF_CHAN_LSB];
  assign new_on = WDATA[`ARF_POWER_BIT];
  // Interval reached; counter holds there until restarted
  assign acq_ok = (acq_q == ACQ_CYCLES);

  // Channel change or power-up restarts the acquisition interval
  assign restart_acq = wr_chan && ((new_chan != chan_q) || (new_on && !on_q));

  // Control, sequencing and result next-state
  always_comb begin
    // Hold every register except the start and done pulses, which default low, unless something below changes it
    chan_d = chan_q;
    on_d = on_q;
    go_d = go_q;
    fmt_d = fmt_q;
    cs_d = cs_q;
    nref_d = nref_q;
    pref_d = pref_q;
    hi_d = hi_q;
    lo_d = lo_q;
    acq_d = acq_q;
    state_d = state_q;
    start_d = 1'b0;
    done_d = 1'b0;

    // Acquisition counter, saturating at the interval
    if (!on_q || restart_acq) begin
      acq_d = '0; // [RL6]
    end else if (state_q == ARF_IDLE && !acq_ok) begin
      acq_d = acq_q + `ARF_ACQ_W'(1);
    end

    // Software writes to result bytes; reserved bits stored as written
    if (wr_hit(WR, ADDR, `ARF_OFS_RES_HI)) begin
      hi_d = WDATA; // [RL9]
    end
    if (wr_hit(WR, ADDR, `ARF_OFS_RES_LO)) begin
      lo_d = WDATA; // [RL9]
    end

    // Conversion sequencing
    unique case (state_q)
      ARF_IDLE: begin
        // Start only once the held sample has settled
        if (go_q && on_q && acq_ok && !restart_acq) begin // [RL6]
          state_d = ARF_CONVERT;
          start_d = 1'b1;
        end
      end
      ARF_CONVERT: begin
        // Power loss abandons the conversion
        if (!on_q) begin
          state_d = ARF_IDLE;
          go_d = 1'b0;
        end else if (CONV_DONE) begin
          // Both bytes land in one edge; beats a same-cycle software write
          {hi_d, lo_d} = pack_result(fmt_q, CONV_RESULT); // [RL7] [RL9]
          go_d = 1'b0;
          done_d = 1'b1;
          state_d = ARF_IDLE;
          acq_d = '0;
        end
      end
    endcase

    // Software write last, so a set of go beats the hardware clear
    if (wr_chan) begin
      chan_d = new_chan;
      on_d = new_on;
      go_d = WDATA[`ARF_GO_BIT];
      if (!WDATA[`ARF_GO_BIT] && state_q == ARF_CONVERT) begin
        state_d = ARF_IDLE; // Abort leaves results untouched unless CONV_DONE comes in the same cycle
      end
    end
    // Format and reference settings; bit 3 is not stored
    if (wr_fmt) begin
      fmt_d = WDATA[`ARF_FMT_BIT];
      cs_d = WDATA[`ARF_CLKSEL_MSB:`ARF_CLKSEL_LSB];
      nref_d = WDATA[`ARF_NREF_BIT];
      pref_d = WDATA[`ARF_PREF_MSB:`ARF_PREF_LSB];
    end
  end

  // Read mux, data valid the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (RD) begin
      // Exact decode; no aliasing of unmapped offsets
      unique case (ADDR)
        `ARF_OFS_CHAN_GO: rdata_d = {1'b0, chan_q, go_q, on_q};
        `ARF_OFS_FMT_REF: rdata_d = {fmt_q, cs_q, 1'b0, nref_q, pref_q};
        `ARF_OFS_RES_HI: rdata_d = hi_q; // [RL5]
        `ARF_OFS_RES_LO: rdata_d = lo_q; // [RL5]
        default: rdata_d = 8'h00; // Unmapped reads as zero
      endcase
    end
  end

  // Register stage
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      chan_q <= 5'h00;
      on_q <= 1'b0;
      go_q <= 1'b0;
      fmt_q <= 1'b0;
      cs_q <= 3'h0;
      nref_q <= 1'b0;
      pref_q <= 2'h0;
      // Results clear to zero; software must not count on it
      {hi_q, lo_q} <= 16'h0000;
      acq_q <= '0;
      state_q <= ARF_IDLE;
      start_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= `ARF_RST_BYTE;
    end else begin
      chan_q <= chan_d;
      on_q <= on_d;
      go_q <= go_d;
      fmt_q <= fmt_d;
      cs_q <= cs_d;
      nref_q <= nref_d;
      pref_q <= pref_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      acq_q <= acq_d;
      state_q <= state_d;
      start_q <= start_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs; no discharge control exists, the held charge carries over
  assign SAMPLE_TRACK = on_q && (state_q == ARF_IDLE); // [RL8]
  assign CONV_START = start_q;
  assign DONE_PULSE = done_q;
  assign RDATA = rdata_q;
  // Converter settings leave as one packed word
  assign CFG = '{channel_select: chan_q, converter_power_on: on_q,
                 conversion_clock_select: cs_q,
                 negative_reference_select: nref_q,
                 positive_reference_select: pref_q};

endmodule // arf_top
`default_nettype wire

//--- design/arf_params.svh
`ifndef ARF_PARAMS_SVH
`define ARF_PARAMS_SVH

// Register offsets on the plain register port
`define ARF_OFS_CHAN_GO 8'h00
`define ARF_OFS_FMT_REF 8'h01
`define ARF_OFS_RES_HI 8'h02
`define ARF_OFS_RES_LO 8'h03

// Field positions in converter_channel_and_go
`define ARF_POWER_BIT 0
`define ARF_GO_BIT 1
`define ARF_CHAN_LSB 2
`define ARF_CHAN_MSB 6

// Field positions in converter_format_and_reference
`define ARF_FMT_BIT 7
`define ARF_CLKSEL_LSB 4
`define ARF_CLKSEL_MSB 6
`define ARF_NREF_BIT 2
`define ARF_PREF_LSB 0
`define ARF_PREF_MSB 1

// Reset values
`define ARF_RST_BYTE 8'h00
`define ARF_RST_RESULT 10'h000

// Result width: 1,024 codes
`define ARF_RES_W 10

// Acquisition interval, least time, rounded up to whole cycles
`define ARF_CLK_PERIOD_PS 100000
`define ARF_ACQ_TIME_PS 7450000
`define ARF_ACQ_CYCLES \
  ((`ARF_ACQ_TIME_PS + `ARF_CLK_PERIOD_PS - 1) / `ARF_CLK_PERIOD_PS)
`define ARF_ACQ_W 7

`endif

//--- design/arf_pkg.sv
`default_nettype none
package arf_pkg;

  // Converter sequencing states
  typedef enum logic [0:0] {
    ARF_IDLE,
    ARF_CONVERT
  } arf_state_t;

  // Settings passed to the analog converter
  typedef struct packed {
    logic [4:0] channel_select;
    logic converter_power_on;
    logic [2:0] conversion_clock_select;
    logic negative_reference_select;
    logic [1:0] positive_reference_select;
  } arf_cfg_t;

endpackage : arf_pkg
`default_nettype wire

//--- sim/arf_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "arf_params.svh"
module arf_monitor (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic CONV_DONE,
  input wire logic CONV_START,
  input wire logic SAMPLE_TRACK,
  input wire logic DONE_PULSE,
  input wire arf_pkg::arf_cfg_t CFG
);
  import arf_pkg::*;
  int acq_q;
  logic [4:0] ch_q;
  // Sampling time since channel change; restarts when tracking stops
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      acq_q <= 0;
      ch_q <= 5'h00;
    end else begin
      ch_q <= CFG.channel_select;
      acq_q <= (!SAMPLE_TRACK || ch_q != CFG.channel_select) ? 0 : acq_q + 1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  property p_acq; CONV_START |-> acq_q >= `ARF_ACQ_CYCLES - 1; endproperty
  a_acq: assert property (p_acq) else $error("start too early");
  property p_pwr; CONV_START |-> CFG.converter_power_on; endproperty
  a_pwr: assert property (p_pwr) else $error("start unpowered");
  property p_st1; CONV_START |=> !CONV_START; endproperty
  a_st1: assert property (p_st1) else $error("start too long");
  property p_done; DONE_PULSE |-> $past(CONV_DONE); endproperty
  a_done: assert property (p_done) else $error("stray done");
  property p_dn1; DONE_PULSE |=> !DONE_PULSE; endproperty
  a_dn1: assert property (p_dn1) else $error("done too long");
  property p_trk; DONE_PULSE |-> SAMPLE_TRACK; endproperty
  a_trk: assert property (p_trk) else $error("no tracking");
  property p_rd0; !$past(RD) |-> RDATA == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("stray rdata");
  c_start: cover property (CONV_START);
  c_done: cover property (DONE_PULSE);
  c_rd: cover property (RD ##1 RDATA != 8'h00);
endmodule // arf_monitor
bind arf_top arf_monitor i_arf_monitor (.CLK(CLK), .RESETN(RESETN),
  .RD(RD), .RDATA(RDATA), .CONV_DONE(CONV_DONE), .CONV_START(CONV_START),
  .SAMPLE_TRACK(SAMPLE_TRACK), .DONE_PULSE(DONE_PULSE), .CFG(CFG));
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import arf_pkg::*;
  logic CLK, RESETN, WR, RD, CONV_DONE, CONV_START, SAMPLE_TRACK, DONE_PULSE;
  logic [7:0] ADDR, WDATA, RDATA, h, l, w, exp_v;
  logic [9:0] CONV_RESULT, r;
  logic pend;
  arf_cfg_t CFG;
  logic [7:0] exp_q[$];
  int err_count, cmp_count, seed, i;
  arf_top i_arf_top (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CONV_DONE(CONV_DONE),
    .CONV_RESULT(CONV_RESULT), .CONV_START(CONV_START),
    .SAMPLE_TRACK(SAMPLE_TRACK), .DONE_PULSE(DONE_PULSE), .CFG(CFG));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic summarize();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_rdata(logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED rdata exp %h got %h", e, s);
    end
  endtask
  task automatic chk_out(string n, logic [11:0] e, logic [11:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  // Start must come within the limit; a timeout is a mismatch
  task automatic wait_start();
    for (i = 0; i < 300 && CONV_START !== 1'b1; i++)
      @(posedge CLK);
    chk_out("conv_start", 12'h001, {11'h000, CONV_START});
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // Expectation queued with the strobe, checked by the watcher
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge CLK);
    exp_q.push_back(e);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
  endtask
  task automatic done(logic [9:0] v);
    @(posedge CLK);
    CONV_DONE <= 1'b1;
    CONV_RESULT <= v;
    @(posedge CLK);
    CONV_DONE <= 1'b0;
  endtask
  // Read data stands only the cycle after the strobe
  always @(posedge CLK) begin
    if (pend) begin
      exp_v = exp_q.pop_front();
      chk_rdata(exp_v, RDATA);
    end
    pend = RD;
  end
  // Hang guard, well beyond the few hundred cycles needed
  initial begin
    #200000;
    err_count++;
    summarize();
  end
  initial begin
    seed = 14;
    RESETN = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    pend = 1'b0;
    CONV_DONE = 1'b0;
    ADDR = 8'h00;
    WDATA = 8'h00;
    CONV_RESULT = 10'h000;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    rd(8'h7f, 8'h00);
    // One conversion in each result format, random code
    for (int f = 0; f < 2; f++) begin
      r = 10'($random(seed));
      w = {f[0], 7'($random(seed))};
      h = f ? {6'h00, r[9:8]} : r[9:2];
      l = f ? r[7:0] : {r[1:0], 6'h00};
      wr(8'h01, w);
      wr(8'h00, 8'h07);
      wait_start();
      chk_out("cfg", {5'h01, 1'b1, w[6:4], w[2], w[1:0]}, CFG);
      done(r);
      rd(8'h02, h);
      rd(8'h03, l);
      rd(8'h01, w & 8'hf7);
      rd(8'h00, 8'h05);
      done(~r);
      rd(8'h02, h);
    end
    // Clearing go mid-conversion aborts; a late done is ignored
    wr(8'h00, 8'h07);
    wait_start();
    wr(8'h00, 8'h05);
    done(~r);
    rd(8'h02, h);
    rd(8'h03, l);
    // Format 1 low byte has no reserved bits to disturb
    wr(8'h03, 8'ha5);
    rd(8'h03, 8'ha5);
    repeat (3) @(posedge CLK);
    summarize();
  end
endmodule // tb
`default_nettype wire
